//--- hdl/psalu_top.sv
// Packed integer SIMD datapath: one operation issued per cycle, result one cycle later.
// The decoder/register file supplies operands; memory transfers arrive as operands too.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Operands are 64 bits; shifts treat them as word/dword/qword lanes.
// - Transfers copy a 32-bit doubleword or the 64-bit quadword.
// - Signed packs narrow words to bytes and dwords to words, clamped signed.
// - Unsigned pack narrows signed words to bytes, clamped to 0..255.
// - Unpacks interleave high or low half lanes of both sources.
// - Plain add works per lane and wraps without carry between lanes.
// - Signed saturating add clamps byte/word lanes to signed limits.
// - Unsigned saturating add clamps byte/word lanes to the unsigned maximum.
// - Plain subtract works per lane and wraps on underflow.
// - Signed saturating subtract clamps byte/word lanes to signed range.
// - Unsigned saturating subtract clamps byte/word lanes at zero.
// - High multiply keeps upper 16 bits of each signed word product.
// - Low multiply keeps lower 16 bits of each signed word product.
// - Multiply-add multiplies word lanes and adds products together.
// - Equality compare yields a per-lane result for byte/word/dword lanes.
// - Greater-than compare is signed: destination lane above source lane.
// - Logic ops: AND, AND-NOT of first operand, OR, XOR over 64 bits.
// - Left logical shift for word/dword/qword, zero filling low bits.
// - Right logical shift for word/dword/qword, zero filling high bits.
// - Arithmetic right shift only for word/dword, sign filling.
// - State clear marks packed register state empty for shared reuse.
module psalu_top (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  op_valid,
  input  wire psalu_pkg::psalu_op_e  op_sel,
  input  wire logic [63:0]           dst_opnd,
  input  wire logic [63:0]           src_opnd,
  input  wire logic [63:0]           shift_count,
  output logic                       res_valid,
  output logic [63:0]                res_data,
  output logic                       simd_state_valid
);

  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] sat_y;
  logic [63:0] next_res;
  logic        sat_sub;
  logic        sat_word;
  logic        sat_signed;

  assign a = dst_opnd;
  assign b = src_opnd;

  // ==========================================================
  // Saturating lanes
  always_comb begin
    sat_sub    = op_sel inside {psalu_pkg::OP_SUB_B_SSAT, psalu_pkg::OP_SUB_W_SSAT,
                                psalu_pkg::OP_SUB_B_USAT, psalu_pkg::OP_SUB_W_USAT};
    sat_word   = op_sel inside {psalu_pkg::OP_ADD_W_SSAT, psalu_pkg::OP_ADD_W_USAT,
                                psalu_pkg::OP_SUB_W_SSAT, psalu_pkg::OP_SUB_W_USAT};
    sat_signed = op_sel inside {psalu_pkg::OP_ADD_B_SSAT, psalu_pkg::OP_ADD_W_SSAT,
                                psalu_pkg::OP_SUB_B_SSAT, psalu_pkg::OP_SUB_W_SSAT};
  end

  psalu_lane_sat u_sat (
    .a          (a),
    .b          (b),
    .sub        (sat_sub),
    .word_lanes (sat_word),
    .is_signed  (sat_signed),
    .y          (sat_y)
  );

  // ==========================================================
  // Per-lane wrap arithmetic, compares, multiplies
  logic [63:0] add_b, add_w, add_d, sub_b, sub_w, sub_d;
  logic [63:0] eq_b, eq_w, eq_d, gt_b, gt_w, gt_d;
  logic [63:0] mul_hi, mul_lo, mul_acc;

  for (genvar i = 0; i < 8; i++) begin : g_b
    assign add_b[8*i+:8] = a[8*i+:8] + b[8*i+:8];
    assign sub_b[8*i+:8] = a[8*i+:8] - b[8*i+:8];
    assign eq_b[8*i+:8]  = {8{a[8*i+:8] == b[8*i+:8]}};
    assign gt_b[8*i+:8]  = {8{$signed(a[8*i+:8]) > $signed(b[8*i+:8])}};
  end

  for (genvar i = 0; i < 4; i++) begin : g_w
    logic signed [31:0] prod;
    assign prod           = 32'($signed(a[16*i+:16])) * 32'($signed(b[16*i+:16]));
    assign add_w[16*i+:16] = a[16*i+:16] + b[16*i+:16];
    assign sub_w[16*i+:16] = a[16*i+:16] - b[16*i+:16];
    assign eq_w[16*i+:16]  = {16{a[16*i+:16] == b[16*i+:16]}};
    assign gt_w[16*i+:16]  = {16{$signed(a[16*i+:16]) > $signed(b[16*i+:16])}};
    assign mul_hi[16*i+:16] = prod[31:16];
    assign mul_lo[16*i+:16] = prod[15:0];
  end

  for (genvar i = 0; i < 2; i++) begin : g_d
    assign add_d[32*i+:32] = a[32*i+:32] + b[32*i+:32];
    assign sub_d[32*i+:32] = a[32*i+:32] - b[32*i+:32];
    assign eq_d[32*i+:32]  = {32{a[32*i+:32] == b[32*i+:32]}};
    assign gt_d[32*i+:32]  = {32{$signed(a[32*i+:32]) > $signed(b[32*i+:32])}};
    // Wraps only for the all -32768 pair case, as a 32-bit adder must
    assign mul_acc[32*i+:32] = g_w[2*i].prod + g_w[2*i+1].prod;
  end

  // ==========================================================
  // Shifts: counts of lane width or more clear the lane or fill with sign
  logic [63:0] shl_w, shl_d, shr_w, shr_d, sar_w, sar_d, shl_q, shr_q;
  logic        big_w, big_d, big_q;
  logic [5:0]  cnt;

  assign cnt   = shift_count[5:0];
  assign big_w = (shift_count > 64'h0000_0000_0000_000f);
  assign big_d = (shift_count > 64'h0000_0000_0000_001f);
  assign big_q = (shift_count > 64'h0000_0000_0000_003f);
  assign shl_q = big_q ? 64'h0 : (a << cnt);
  assign shr_q = big_q ? 64'h0 : (a >> cnt);

  for (genvar i = 0; i < 4; i++) begin : g_sw
    assign shl_w[16*i+:16] = big_w ? 16'h0 : (a[16*i+:16] << cnt[3:0]);
    assign shr_w[16*i+:16] = big_w ? 16'h0 : (a[16*i+:16] >> cnt[3:0]);
    assign sar_w[16*i+:16] = big_w ? {16{a[16*i+15]}}
                                   : 16'($signed(a[16*i+:16]) >>> cnt[3:0]);
  end

  for (genvar i = 0; i < 2; i++) begin : g_sd
    assign shl_d[32*i+:32] = big_d ? 32'h0 : (a[32*i+:32] << cnt[4:0]);
    assign shr_d[32*i+:32] = big_d ? 32'h0 : (a[32*i+:32] >> cnt[4:0]);
    assign sar_d[32*i+:32] = big_d ? {32{a[32*i+31]}}
                                   : 32'($signed(a[32*i+:32]) >>> cnt[4:0]);
  end

  // ==========================================================
  // Packs and unpacks
  logic [63:0] pk_wb_s, pk_dw_s, pk_wb_u;

  function automatic logic [7:0] psalu_w2b_s(input logic [15:0] w);
    if ($signed(w) > 16'sd127)       return 8'h7f;
    else if ($signed(w) < -16'sd128) return 8'h80;
    else                             return w[7:0];
  endfunction

  function automatic logic [7:0] psalu_w2b_u(input logic [15:0] w);
    if (w[15])               return 8'h00;
    else if (w[14:8] != 7'h0) return 8'hff;
    else                     return w[7:0];
  endfunction

  function automatic logic [15:0] psalu_d2w_s(input logic [31:0] d);
    if ($signed(d) > 32'sd32767)       return 16'h7fff;
    else if ($signed(d) < -32'sd32768) return 16'h8000;
    else                               return d[15:0];
  endfunction

  // Destination fills the low half, source the high half
  for (genvar i = 0; i < 4; i++) begin : g_pk
    assign pk_wb_s[8*i+:8]      = psalu_w2b_s(a[16*i+:16]);
    assign pk_wb_s[32+8*i+:8]   = psalu_w2b_s(b[16*i+:16]);
    assign pk_wb_u[8*i+:8]      = psalu_w2b_u(a[16*i+:16]);
    assign pk_wb_u[32+8*i+:8]   = psalu_w2b_u(b[16*i+:16]);
  end
  for (genvar i = 0; i < 2; i++) begin : g_pkd
    assign pk_dw_s[16*i+:16]    = psalu_d2w_s(a[32*i+:32]);
    assign pk_dw_s[32+16*i+:16] = psalu_d2w_s(b[32*i+:32]);
  end

  logic [63:0] up_hb, up_lb, up_hw, up_lw, up_hd, up_ld;
  for (genvar i = 0; i < 4; i++) begin : g_ub
    assign up_lb[16*i+:16] = {b[8*i+:8], a[8*i+:8]};
    assign up_hb[16*i+:16] = {b[32+8*i+:8], a[32+8*i+:8]};
  end
  for (genvar i = 0; i < 2; i++) begin : g_uw
    assign up_lw[32*i+:32] = {b[16*i+:16], a[16*i+:16]};
    assign up_hw[32*i+:32] = {b[32+16*i+:16], a[32+16*i+:16]};
  end
  assign up_ld = {b[31:0], a[31:0]};
  assign up_hd = {b[63:32], a[63:32]};

  // ==========================================================
  // Result select
  always_comb begin
    next_res = psalu_pkg::RESULT_RST;
    unique case (op_sel)
      psalu_pkg::OP_MOVE_DWORD:   next_res = {32'h0, b[31:0]};
      psalu_pkg::OP_MOVE_QWORD:   next_res = b;
      psalu_pkg::OP_PACK_WB_SSAT: next_res = pk_wb_s;
      psalu_pkg::OP_PACK_DW_SSAT: next_res = pk_dw_s;
      psalu_pkg::OP_PACK_WB_USAT: next_res = pk_wb_u;
      psalu_pkg::OP_UNPACK_HI_B:  next_res = up_hb;
      psalu_pkg::OP_UNPACK_HI_W:  next_res = up_hw;
      psalu_pkg::OP_UNPACK_HI_D:  next_res = up_hd;
      psalu_pkg::OP_UNPACK_LO_B:  next_res = up_lb;
      psalu_pkg::OP_UNPACK_LO_W:  next_res = up_lw;
      psalu_pkg::OP_UNPACK_LO_D:  next_res = up_ld;
      psalu_pkg::OP_ADD_B:        next_res = add_b;
      psalu_pkg::OP_ADD_W:        next_res = add_w;
      psalu_pkg::OP_ADD_D:        next_res = add_d;
      psalu_pkg::OP_ADD_B_SSAT,
      psalu_pkg::OP_ADD_W_SSAT,
      psalu_pkg::OP_ADD_B_USAT,
      psalu_pkg::OP_ADD_W_USAT,
      psalu_pkg::OP_SUB_B_SSAT,
      psalu_pkg::OP_SUB_W_SSAT,
      psalu_pkg::OP_SUB_B_USAT,
      psalu_pkg::OP_SUB_W_USAT:   next_res = sat_y;
      psalu_pkg::OP_SUB_B:        next_res = sub_b;
      psalu_pkg::OP_SUB_W:        next_res = sub_w;
      psalu_pkg::OP_SUB_D:        next_res = sub_d;
      psalu_pkg::OP_MUL_HIGH:     next_res = mul_hi;
      psalu_pkg::OP_MUL_LOW:      next_res = mul_lo;
      psalu_pkg::OP_MUL_ACC:      next_res = mul_acc;
      psalu_pkg::OP_EQ_B:         next_res = eq_b;
      psalu_pkg::OP_EQ_W:         next_res = eq_w;
      psalu_pkg::OP_EQ_D:         next_res = eq_d;
      psalu_pkg::OP_GT_B:         next_res = gt_b;
      psalu_pkg::OP_GT_W:         next_res = gt_w;
      psalu_pkg::OP_GT_D:         next_res = gt_d;
      psalu_pkg::OP_AND:          next_res = a & b;
      psalu_pkg::OP_ANDNOT:       next_res = ~a & b;
      psalu_pkg::OP_OR:           next_res = a | b;
      psalu_pkg::OP_XOR:          next_res = a ^ b;
      psalu_pkg::OP_SHL_W:        next_res = shl_w;
      psalu_pkg::OP_SHL_D:        next_res = shl_d;
      psalu_pkg::OP_SHL_Q:        next_res = shl_q;
      psalu_pkg::OP_SHR_W:        next_res = shr_w;
      psalu_pkg::OP_SHR_D:        next_res = shr_d;
      psalu_pkg::OP_SHR_Q:        next_res = shr_q;
      psalu_pkg::OP_SAR_W:        next_res = sar_w;
      psalu_pkg::OP_SAR_D:        next_res = sar_d;
      psalu_pkg::OP_CLEAR_STATE:  next_res = psalu_pkg::RESULT_RST;
      default:                    next_res = psalu_pkg::RESULT_RST;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      res_data  <= psalu_pkg::RESULT_RST;
      res_valid <= 1'b0;
    end else begin
      res_valid <= op_valid && (op_sel != psalu_pkg::OP_CLEAR_STATE);
      if (op_valid) begin
        res_data <= next_res;
      end
    end
  end

  // Any packed op marks the state in use; clear empties it for shared reuse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      simd_state_valid <= psalu_pkg::STATE_RST;
    end else if (op_valid) begin
      simd_state_valid <= (op_sel != psalu_pkg::OP_CLEAR_STATE);
    end
  end

  // ==========================================================
  // Checks
  // An op seen on the last reset edge is dropped, so it must arm no check
  logic op_taken;
  assign op_taken = op_valid && !sys_rst;

  AST_CLEAR_EMPTIES: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_CLEAR_STATE |=> !simd_state_valid && !res_valid)
    else $error("State clear did not empty state");

  AST_ADD_B_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_ADD_B
    |=> res_data[7:0] == 8'($past(dst_opnd[7:0]) + $past(src_opnd[7:0])))
    else $error("Byte add lane 0 wrong");

  AST_SSAT_ADD_W: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_ADD_W_SSAT && dst_opnd[15:0] == 16'h7fff
    && !src_opnd[15] |=> res_data[15:0] == 16'h7fff)
    else $error("Signed word add did not saturate high");

  AST_USAT_SUB_B: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_SUB_B_USAT && dst_opnd[7:0] < src_opnd[7:0]
    |=> res_data[7:0] == 8'h00)
    else $error("Unsigned byte sub did not clamp at zero");

  AST_EQ_MASK: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_EQ_W
    |=> res_data[15:0] == ($past(dst_opnd[15:0]) == $past(src_opnd[15:0]) ? 16'hffff : 16'h0))
    else $error("Word equality mask wrong");

  AST_MUL_HI: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_MUL_HIGH && dst_opnd[15:0] == 16'h8000
    && src_opnd[15:0] == 16'h8000 |=> res_data[15:0] == 16'h4000)
    else $error("High multiply lane wrong");

  AST_SAR_SIGN: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_SAR_D && dst_opnd[63] && shift_count > 64'h1f
    |=> res_data[63:32] == 32'hffff_ffff)
    else $error("Arithmetic dword shift lost sign");

  AST_MOVE_DWORD_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_MOVE_DWORD |=> res_valid && res_data[63:32] == 32'h0)
    else $error("Doubleword move left upper half");

  AST_PACK_U: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_PACK_WB_USAT && dst_opnd[15]
    |=> res_data[7:0] == 8'h00)
    else $error("Unsigned pack of negative word not zero");

  AST_ADD_D_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_ADD_D
    |=> res_data[63:32] == 32'($past(dst_opnd[63:32]) + $past(src_opnd[63:32])))
    else $error("Dword add lane 1 wrong");

  AST_SUB_W_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_SUB_W
    |=> res_data[31:16] == 16'($past(dst_opnd[31:16]) - $past(src_opnd[31:16])))
    else $error("Word subtract lane 1 wrong");

  AST_USAT_ADD_B: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_ADD_B_USAT && dst_opnd[7] && src_opnd[7]
    |=> res_data[7:0] == 8'hff)
    else $error("Unsigned byte add did not clamp");

  AST_GT_SIGN: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_GT_D && !dst_opnd[31] && src_opnd[31]
    |=> res_data[31:0] == 32'hffff_ffff)
    else $error("Signed dword compare ignored sign");

  AST_XOR_ALL: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_XOR
    |=> res_data == ($past(dst_opnd) ^ $past(src_opnd)))
    else $error("Exclusive or wrong");

  AST_SHL_Q_BIG: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_SHL_Q && shift_count > 64'h3f
    |=> res_data == 64'h0)
    else $error("Quadword shift past width not zero");

  AST_UNPACK_LO: assert property (@(posedge mclk) disable iff (sys_rst)
    op_taken && op_sel == psalu_pkg::OP_UNPACK_LO_D
    |=> res_data == {$past(src_opnd[31:0]), $past(dst_opnd[31:0])})
    else $error("Low dword unpack wrong");

  COV_SAT_ADD: cover property (@(posedge mclk) op_valid && op_sel == psalu_pkg::OP_ADD_B_SSAT);
  COV_MUL_ACC: cover property (@(posedge mclk) op_valid && op_sel == psalu_pkg::OP_MUL_ACC);
  COV_CLEAR:   cover property (@(posedge mclk) simd_state_valid ##1 !simd_state_valid);
  COV_SSAT_HI: cover property (@(posedge mclk) op_taken && op_sel == psalu_pkg::OP_ADD_W_SSAT
    && dst_opnd[15:0] == 16'h7fff);
  COV_BACK2BACK: cover property (@(posedge mclk) op_taken ##1 op_taken);

endmodule

`default_nettype wire

//--- pkg/psalu_pkg.sv
// Package for the packed integer SIMD datapath: operation codes and lane constants.
// Assumes one core clock; the decoder supplies one operation per issue.
`default_nettype none
package psalu_pkg;

  // ==========================================================
  // Operation select
  typedef enum logic [5:0] {
    OP_MOVE_DWORD      = 6'h00,
    OP_MOVE_QWORD      = 6'h01,
    OP_PACK_WB_SSAT    = 6'h02,
    OP_PACK_DW_SSAT    = 6'h03,
    OP_PACK_WB_USAT    = 6'h04,
    OP_UNPACK_HI_B     = 6'h05,
    OP_UNPACK_HI_W     = 6'h06,
    OP_UNPACK_HI_D     = 6'h07,
    OP_UNPACK_LO_B     = 6'h08,
    OP_UNPACK_LO_W     = 6'h09,
    OP_UNPACK_LO_D     = 6'h0a,
    OP_ADD_B           = 6'h0b,
    OP_ADD_W           = 6'h0c,
    OP_ADD_D           = 6'h0d,
    OP_ADD_B_SSAT      = 6'h0e,
    OP_ADD_W_SSAT      = 6'h0f,
    OP_ADD_B_USAT      = 6'h10,
    OP_ADD_W_USAT      = 6'h11,
    OP_SUB_B           = 6'h12,
    OP_SUB_W           = 6'h13,
    OP_SUB_D           = 6'h14,
    OP_SUB_B_SSAT      = 6'h15,
    OP_SUB_W_SSAT      = 6'h16,
    OP_SUB_B_USAT      = 6'h17,
    OP_SUB_W_USAT      = 6'h18,
    OP_MUL_HIGH        = 6'h19,
    OP_MUL_LOW         = 6'h1a,
    OP_MUL_ACC         = 6'h1b,
    OP_EQ_B            = 6'h1c,
    OP_EQ_W            = 6'h1d,
    OP_EQ_D            = 6'h1e,
    OP_GT_B            = 6'h1f,
    OP_GT_W            = 6'h20,
    OP_GT_D            = 6'h21,
    OP_AND             = 6'h22,
    OP_ANDNOT          = 6'h23,
    OP_OR              = 6'h24,
    OP_XOR             = 6'h25,
    OP_SHL_W           = 6'h26,
    OP_SHL_D           = 6'h27,
    OP_SHL_Q           = 6'h28,
    OP_SHR_W           = 6'h29,
    OP_SHR_D           = 6'h2a,
    OP_SHR_Q           = 6'h2b,
    OP_SAR_W           = 6'h2c,
    OP_SAR_D           = 6'h2d,
    OP_CLEAR_STATE     = 6'h2e
  } psalu_op_e;

  // ==========================================================
  // Widths and reset values
  localparam int unsigned OPERAND_W  = 64;
  localparam int unsigned DWORD_W    = 32;
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic        STATE_RST  = 1'b0;

endpackage

`default_nettype wire

//--- hdl/psalu_lane_sat.sv
// Saturating add/subtract of the eight byte lanes or four word lanes of a quadword.
// Purely combinational; the parent registers the result.
`timescale 1ns/1ps
`default_nettype none

module psalu_lane_sat (
  input  wire logic [63:0] a,
  input  wire logic [63:0] b,
  input  wire logic        sub,
  input  wire logic        word_lanes,
  input  wire logic        is_signed,
  output logic      [63:0] y
);

  logic [63:0] yb;
  logic [63:0] yw;

  // ==========================================================
  // Byte lanes
  for (genvar i = 0; i < 8; i++) begin : g_byte
    logic signed [9:0] s;
    logic        [9:0] u;
    always_comb begin
      s = sub ? ($signed({{2{a[8*i+7]}}, a[8*i+:8]}) - $signed({{2{b[8*i+7]}}, b[8*i+:8]}))
              : ($signed({{2{a[8*i+7]}}, a[8*i+:8]}) + $signed({{2{b[8*i+7]}}, b[8*i+:8]}));
      u = sub ? ({2'h0, a[8*i+:8]} - {2'h0, b[8*i+:8]})
              : ({2'h0, a[8*i+:8]} + {2'h0, b[8*i+:8]});
      if (is_signed) begin
        if (s > 10'sd127)       yb[8*i+:8] = 8'h7f;
        else if (s < -10'sd128) yb[8*i+:8] = 8'h80;
        else                    yb[8*i+:8] = s[7:0];
      end else begin
        if (u[9])               yb[8*i+:8] = 8'h00;
        else if (u[8])          yb[8*i+:8] = 8'hff;
        else                    yb[8*i+:8] = u[7:0];
      end
    end
  end

  // ==========================================================
  // Word lanes
  for (genvar i = 0; i < 4; i++) begin : g_word
    logic signed [17:0] s;
    logic        [17:0] u;
    always_comb begin
      s = sub ? ($signed({{2{a[16*i+15]}}, a[16*i+:16]}) - $signed({{2{b[16*i+15]}}, b[16*i+:16]}))
              : ($signed({{2{a[16*i+15]}}, a[16*i+:16]}) + $signed({{2{b[16*i+15]}}, b[16*i+:16]}));
      u = sub ? ({2'h0, a[16*i+:16]} - {2'h0, b[16*i+:16]})
              : ({2'h0, a[16*i+:16]} + {2'h0, b[16*i+:16]});
      if (is_signed) begin
        if (s > 18'sd32767)       yw[16*i+:16] = 16'h7fff;
        else if (s < -18'sd32768) yw[16*i+:16] = 16'h8000;
        else                      yw[16*i+:16] = s[15:0];
      end else begin
        if (u[17])                yw[16*i+:16] = 16'h0000;
        else if (u[16])           yw[16*i+:16] = 16'hffff;
        else                      yw[16*i+:16] = u[15:0];
      end
    end
  end

  assign y = word_lanes ? yw : yb;

endmodule

`default_nettype wire

//--- test/psalu_issuer.sv
// Issue-side model of the decoder and register file feeding the datapath.
// Assumes the caller invokes drive just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module psalu_issuer (
  output logic                 op_valid,
  output psalu_pkg::psalu_op_e op_sel,
  output logic [63:0]          dst_opnd,
  output logic [63:0]          src_opnd,
  output logic [63:0]          shift_count
);
  initial begin
    op_valid = 1'b0;
    op_sel = psalu_pkg::OP_MOVE_DWORD;
    dst_opnd = 64'h0;
    src_opnd = 64'h0;
    shift_count = 64'h0;
  end
  // Idle operands toggle so a stale value is never mistaken for a live one
  task automatic drive(logic v, psalu_pkg::psalu_op_e op, logic [63:0] a, b, s);
    op_valid <= v;
    op_sel <= op;
    dst_opnd <= v ? a : ~dst_opnd;
    src_opnd <= v ? b : ~src_opnd;
    shift_count <= v ? s : ~shift_count;
  endtask
endmodule
`default_nettype wire

//--- test/tb_packed_simd_integer_alu.sv
// Self-checking bench: every opcode swept, then random ops with resets between.
// Assumes one result per issued op, visible just after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module tb_packed_simd_integer_alu;
  logic                 mclk;
  logic                 sys_rst;
  logic                 op_valid;
  psalu_pkg::psalu_op_e op_sel;
  logic [63:0]          dst_opnd;
  logic [63:0]          src_opnd;
  logic [63:0]          shift_count;
  logic                 res_valid;
  logic [63:0]          res_data;
  logic                 simd_state_valid;
  int                   bad_count = 0;
  int                   tests_run = 0;
  logic [31:0]          seed = 32'h797b1850;
  localparam logic [63:0] CORNER [5] = '{64'h0, '1, 64'h7f7f_7fff_ffff_7fff,
    64'h8080_8000_0000_8000, 64'h00ff_7f80_ff01_0080};

  psalu_issuer iss (.op_valid(op_valid), .op_sel(op_sel), .dst_opnd(dst_opnd),
    .src_opnd(src_opnd), .shift_count(shift_count));
  psalu_top dut (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .op_sel(op_sel),
    .dst_opnd(dst_opnd), .src_opnd(src_opnd), .shift_count(shift_count),
    .res_valid(res_valid), .res_data(res_data), .simd_state_valid(simd_state_valid));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] pick();
    logic [31:0] t;
    t = xs();
    return t[3] ? {xs(), xs()} : CORNER[t[2:0] % 5];
  endfunction
  function automatic longint ug(logic [63:0] v, int i, int w);
    return longint'((v >> (i * w)) & ((64'h1 << w) - 64'h1));
  endfunction
  function automatic longint sg(logic [63:0] v, int i, int w);
    longint t;
    t = ug(v, i, w);
    return t[w-1] ? t - (longint'(1) << w) : t;
  endfunction
  function automatic longint cl(longint v, longint lo, longint hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  function automatic logic [63:0] pl(longint z, int i, int w);
    return (64'(z) & ((64'h1 << w) - 64'h1)) << (i * w);
  endfunction
  // Lane kind in the low nibble of k, lane size index above it
  function automatic logic [63:0] ref_res(logic [5:0] op, logic [63:0] a, b, s);
    logic [63:0] r;
    longint      x, y, z, lo, hi;
    int          w, k, n;
    r = 64'h0;
    k = -1;
    case (op)
      6'h00: r = {32'h0, b[31:0]};
      6'h01: r = b;
      6'h02, 6'h03, 6'h04: begin
        w = (op == 6'h03) ? 32 : 16;
        hi = (op == 6'h04) ? 255 : (longint'(1) << (w / 2 - 1)) - 1;
        lo = (op == 6'h04) ? 0 : -hi - 1;
        for (int i = 0; i < 64 / w; i++) begin
          r |= pl(cl(sg(a, i, w), lo, hi), i, w / 2);
          r |= pl(cl(sg(b, i, w), lo, hi), i + 64 / w, w / 2);
        end
      end
      6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a: begin
        w = 8 << int'((op - 6'h05) % 3);
        n = (op < 6'h08) ? 32 / w : 0;
        for (int i = 0; i < 32 / w; i++) begin
          r |= pl(ug(a, i + n, w), 2 * i, w);
          r |= pl(ug(b, i + n, w), 2 * i + 1, w);
        end
      end
      6'h0b, 6'h0c, 6'h0d: k = 16 * (op - 6'h0b);
      6'h0e, 6'h0f: k = 1 + 16 * (op - 6'h0e);
      6'h10, 6'h11: k = 2 + 16 * (op - 6'h10);
      6'h12, 6'h13, 6'h14: k = 3 + 16 * (op - 6'h12);
      6'h15, 6'h16: k = 4 + 16 * (op - 6'h15);
      6'h17, 6'h18: k = 5 + 16 * (op - 6'h17);
      6'h19: k = 27;
      6'h1a: k = 28;
      6'h1b: for (int i = 0; i < 2; i++) begin
        r |= pl(sg(a, 2*i, 16) * sg(b, 2*i, 16) + sg(a, 2*i+1, 16) * sg(b, 2*i+1, 16), i, 32);
      end
      6'h1c, 6'h1d, 6'h1e: k = 6 + 16 * (op - 6'h1c);
      6'h1f, 6'h20, 6'h21: k = 7 + 16 * (op - 6'h1f);
      6'h22: r = a & b;
      6'h23: r = ~a & b;
      6'h24: r = a | b;
      6'h25: r = a ^ b;
      6'h26, 6'h27: k = 24 + 16 * (op - 6'h26);
      6'h28: r = (s > 64'd63) ? 64'h0 : a << s[5:0];
      6'h29, 6'h2a: k = 25 + 16 * (op - 6'h29);
      6'h2b: r = (s > 64'd63) ? 64'h0 : a >> s[5:0];
      6'h2c, 6'h2d: k = 26 + 16 * (op - 6'h2c);
      default: r = 64'h0;
    endcase
    if (k >= 0) begin
      w = 8 << (k / 16);
      hi = (longint'(1) << w) - 1;
      for (int i = 0; i < 64 / w; i++) begin
        x = sg(a, i, w);
        y = sg(b, i, w);
        case (k % 16)
          0: z = x + y;
          1: z = cl(x + y, -(hi + 1) / 2, hi / 2);
          2: z = cl(ug(a, i, w) + ug(b, i, w), 0, hi);
          3: z = x - y;
          4: z = cl(x - y, -(hi + 1) / 2, hi / 2);
          5: z = cl(ug(a, i, w) - ug(b, i, w), 0, hi);
          6: z = (x == y) ? -1 : 0;
          7: z = (x > y) ? -1 : 0;
          8: z = (s >= 64'(w)) ? 0 : x << s[5:0];
          9: z = (s >= 64'(w)) ? 0 : ug(a, i, w) >> s[5:0];
          10: z = (s >= 64'(w)) ? x >>> 63 : x >>> s[5:0];
          11: z = (x * y) >>> 16;
          default: z = x * y;
        endcase
        r |= pl(z, i, w);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Checking and verdict
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #60000;
    bad_count++;
    final_report();
  end

  // ==========================================================
  // Main sequence: sweep all codes, then random traffic; reset every 1000
  initial begin
    logic [5:0]  op, pop;
    logic [63:0] a, b, s, pexp;
    logic        v, pv, es, r;
    int          g;
    sys_rst = 1'b1;
    pv = 1'b0;
    pop = 6'h0;
    pexp = 64'h0;
    es = 1'b0;
    repeat (8) @(posedge mclk);
    for (int n = 0; n < 3000; n++) begin
      @(posedge mclk);
      r = (n % 1000 == 999);
      sys_rst <= r;
      v = n < 144 || xs() % 4 != 0;
      op = (n < 144) ? 6'(n % 48) : 6'(xs() % 48);
      a = pick();
      b = pick();
      // Later sweeps feed equal corner operands so the clamp edges are reached
      if (n >= 48 && n < 144) begin
        a = CORNER[n / 48 + 1];
        b = a;
      end
      s = (xs() % 8 == 0) ? {xs(), xs()} : 64'(xs() % 40);
      iss.drive(v, psalu_pkg::psalu_op_e'(op), a, b, s);
      #1;
      g = (pop < 6'h0b) ? 0 : (pop < 6'h19) ? 1 : (pop < 6'h22) ? 2 : 3;
      check(64'(res_valid), 64'(pv && pop != 6'h2e));
      check(64'(simd_state_valid), 64'(es));
      if (g == 0) check(res_data, pexp);
      if (g == 1) check(res_data, pexp);
      if (g == 2) check(res_data, pexp);
      if (g == 3) check(res_data, pexp);
      pv = v && !r;
      if (pv) begin
        pop = op;
        pexp = ref_res(op, a, b, s);
        es = (op != 6'h2e);
      end
      if (r) begin
        pexp = 64'h0;
        es = 1'b0;
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
